/* File: rtl/ckm_cfg.svh */
// constants of the clock manager control block
`ifndef CKM_CFG_SVH
`define CKM_CFG_SVH
`define CKM_ADDR_W        7
`define CKM_DATA_W        16
`define CKM_CELL_DEPTH    128
`define CKM_CELL_RST      16'h0000
`define CKM_CLK_SYS_NS    4
// time without a reference edge before the clock counts as stopped
`define CKM_STOP_NS       1000
`define CKM_STOP_CYC      ((`CKM_STOP_NS + `CKM_CLK_SYS_NS - 1) / `CKM_CLK_SYS_NS)
// reference edges needed for lock
`define CKM_LOCK_EDGES    64
// system cycles from a phase step request to its done pulse
`define CKM_PS_NS         200
`define CKM_PS_CYC        ((`CKM_PS_NS + `CKM_CLK_SYS_NS - 1) / `CKM_CLK_SYS_NS)
// system cycles from a write to its commit into the cells
`define CKM_COMMIT_NS     40
`define CKM_COMMIT_CYC    ((`CKM_COMMIT_NS + `CKM_CLK_SYS_NS - 1) / `CKM_CLK_SYS_NS)
`endif

/* File: rtl/ckm_pkg.sv */
// types of the clock manager control block
package ckm_pkg;
  typedef enum logic [3:0] {
    CKM_PORT_IDLE   = 4'b0001,
    CKM_PORT_READ   = 4'b0010,
    CKM_PORT_WRITE  = 4'b0100,
    CKM_PORT_COMMIT = 4'b1000
  } ckm_port_e;
  typedef logic [15:0] ckm_word_t;
  typedef logic [6:0]  ckm_addr_t;
endpackage

/* File: rtl/ckm_sync.sv */
// three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module ckm_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;
  always_comb begin
    sh_d  = {sh_q[1:0], i_async};
    lvl_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : lvl_q;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q  <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      sh_q  <= sh_d;
      lvl_q <= lvl_d;
    end
  end
  assign o_level = lvl_q;
  assign o_rise  = lvl_d & ~lvl_q;
endmodule // ckm_sync

/* File: rtl/ckm_clk_mon.sv */
// edge watchdog and lock counter for one sampled clock
`timescale 1ns/1ps
`include "ckm_cfg.svh"
module ckm_clk_mon (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_clear,
  input  wire logic i_edge,
  output logic      o_stopped,
  output logic      o_locked
);
  logic [15:0] idle_q;
  logic [15:0] idle_d;
  logic [7:0]  seen_q;
  logic [7:0]  seen_d;
  always_comb begin
    idle_d = idle_q;
    seen_d = seen_q;
    if (i_clear) begin
      idle_d = 16'h0000;
      seen_d = 8'h00;
    end else if (i_edge) begin
      idle_d = 16'h0000;
      if (seen_q != 8'(`CKM_LOCK_EDGES)) seen_d = seen_q + 8'h01;
    end else if (idle_q != 16'(`CKM_STOP_CYC)) begin
      idle_d = idle_q + 16'h0001;
    end else begin
      // a stopped clock loses lock and must restart counting
      seen_d = 8'h00;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_q <= 16'h0000;
      seen_q <= 8'h00;
    end else begin
      idle_q <= idle_d;
      seen_q <= seen_d;
    end
  end
  assign o_stopped = (idle_q == 16'(`CKM_STOP_CYC));
  assign o_locked  = (seen_q == 8'(`CKM_LOCK_EDGES)) && !o_stopped;
endmodule // ckm_clk_mon

/* File: rtl/ckm_ctrl.sv */
// control and status ports of the clock synthesis unit
// Function
// - control and status signals are active high except the main reset, which is active low
// - select high picks primary reference, low picks secondary
// - main reset acts asynchronously, unit reset through the synchroniser; operation resumes synchronously after release
// - lock is acquired after power-up without an extra reset
// - lock rises on alignment and drops on reference stop or lost alignment
// - a status output reports the reference clock stopped
// - a separate status output reports the feedback clock stopped
// - power down makes the unit fully inactive; O_REF_CLK_SEL still follows the select and a started port access finishes
// - seven-bit address selects one sixteen-bit cell group
// - written data go to a shadow register, committed later
// - ready says another write may start; user waits for it
// - strobe with write enable writes, without it reads
// - no port operation happens without the strobe
// - port signals are referenced to the port clock rising edge
// - phase step inputs are referenced to the phase step clock
// - unit acknowledges when the divide change completes
// - direction high increments, low decrements
// - phase step done pulses one phase step clock cycle on completion
`timescale 1ns/1ps
`include "ckm_cfg.svh"
module ckm_ctrl (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET_N,
  input  wire logic        I_PRIMARY_REF_CLK,
  input  wire logic        I_SECONDARY_REF_CLK,
  input  wire logic        I_REF_SELECT,
  input  wire logic        I_FEEDBACK_CLK_IN,
  input  wire logic        I_UNIT_RESET,
  input  wire logic        I_POWER_DOWN,
  input  wire logic        I_CFG_CLK,
  input  wire logic [6:0]  I_CFG_ADDR,
  input  wire logic [15:0] I_CFG_WDATA,
  input  wire logic        I_CFG_WRITE_EN,
  input  wire logic        I_CFG_STROBE,
  input  wire logic        I_PHASE_STEP_CLK,
  input  wire logic        I_PHASE_STEP_GO,
  input  wire logic        I_PHASE_STEP_DIR,
  input  wire logic        I_DIVIDE_CHANGE_REQ,
  output logic             O_REF_CLK_SEL,
  output logic             O_LOCKED,
  output logic             O_REF_CLK_STOP_FLAG,
  output logic             O_FB_CLK_STOP_FLAG,
  output logic [15:0]      O_CFG_RDATA,
  output logic             O_CFG_READY,
  output logic             O_PHASE_STEP_DONE,
  output logic             O_DIVIDE_CHANGE_ACK,
  output logic [15:0]      O_PHASE_POS
);
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) rst_sync_q <= 2'h0;
    else            rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // every outside single-bit signal except the main reset enters through the synchroniser
  logic p_rise, s_rise, fb_rise, sel_lvl, sel_n_lvl, urst_lvl, pd_lvl;
  logic cfg_clk_rise, sclk_rise, den_lvl, dwe_lvl, go_lvl, dir_lvl, req_lvl;
  ckm_sync u_s_p (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_PRIMARY_REF_CLK), .o_level(), .o_rise(p_rise));
  ckm_sync u_s_s (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_SECONDARY_REF_CLK), .o_level(), .o_rise(s_rise));
  ckm_sync u_s_fb (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_FEEDBACK_CLK_IN), .o_level(), .o_rise(fb_rise));
  // select travels inverted so that the synchroniser's reset level means primary, like the output
  ckm_sync u_s_sel (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(~I_REF_SELECT), .o_level(sel_n_lvl), .o_rise());
  assign sel_lvl = ~sel_n_lvl;
  ckm_sync u_s_urst (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_UNIT_RESET), .o_level(urst_lvl), .o_rise());
  ckm_sync u_s_pd (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_POWER_DOWN), .o_level(pd_lvl), .o_rise());
  ckm_sync u_s_cfg_clk (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_CFG_CLK), .o_level(), .o_rise(cfg_clk_rise));
  ckm_sync u_s_den (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_CFG_STROBE), .o_level(den_lvl), .o_rise());
  ckm_sync u_s_dwe (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_CFG_WRITE_EN), .o_level(dwe_lvl), .o_rise());
  ckm_sync u_s_sclk (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_PHASE_STEP_CLK), .o_level(), .o_rise(sclk_rise));
  ckm_sync u_s_go (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_PHASE_STEP_GO), .o_level(go_lvl), .o_rise());
  ckm_sync u_s_dir (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_PHASE_STEP_DIR), .o_level(dir_lvl), .o_rise());
  ckm_sync u_s_req (.i_clk(I_CLK_SYS), .i_rst_n(rst_n),
    .i_async(I_DIVIDE_CHANGE_REQ), .o_level(req_lvl), .o_rise());

  // buses are held steady around the port clock edge, so a three-stage copy is safe
  // same depth as the strobe path, so the fields taken are those that stood before the port clock edge
  logic [6:0]  addr_s1_q, addr_s2_q, addr_s3_q, addr_q;
  logic [15:0] wd_s1_q, wd_s2_q, wd_s3_q, wd_q;
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      addr_s1_q <= 7'h00;
      addr_s2_q <= 7'h00;
      addr_s3_q <= 7'h00;
      addr_q    <= 7'h00;
      wd_s1_q   <= 16'h0000;
      wd_s2_q   <= 16'h0000;
      wd_s3_q   <= 16'h0000;
      wd_q      <= 16'h0000;
    end else begin
      addr_s1_q <= I_CFG_ADDR;
      addr_s2_q <= addr_s1_q;
      addr_s3_q <= addr_s2_q;
      addr_q    <= (addr_s3_q == addr_s2_q) ? addr_s3_q : addr_q;
      wd_s1_q   <= I_CFG_WDATA;
      wd_s2_q   <= wd_s1_q;
      wd_s3_q   <= wd_s2_q;
      wd_q      <= (wd_s3_q == wd_s2_q) ? wd_s3_q : wd_q;
    end
  end

  // unit held inactive by its own reset or by power down
  logic hold;
  assign hold = urst_lvl | pd_lvl;
  logic ref_rise;
  assign ref_rise = sel_lvl ? p_rise : s_rise;

  logic ref_stop, ref_lock, fb_stop, fb_lock;
  ckm_clk_mon u_mon_ref (
    .i_clk     (I_CLK_SYS),
    .i_rst_n   (rst_n),
    .i_clear   (hold),
    .i_edge    (ref_rise),
    .o_stopped (ref_stop),
    .o_locked  (ref_lock)
  );
  ckm_clk_mon u_mon_fb (
    .i_clk     (I_CLK_SYS),
    .i_rst_n   (rst_n),
    .i_clear   (hold),
    .i_edge    (fb_rise),
    .o_stopped (fb_stop),
    .o_locked  (fb_lock)
  );

  // status registers; lock needs both clocks running and counted, no reset pulse needed
  logic lock_q, lock_d, rstop_q, rstop_d, fstop_q, fstop_d, sel_q, sel_d;
  always_comb begin
    sel_d   = sel_lvl;
    lock_d  = !hold && ref_lock && fb_lock;
    rstop_d = !pd_lvl && ref_stop;
    fstop_d = !pd_lvl && fb_stop;
  end
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      lock_q  <= 1'b0;
      rstop_q <= 1'b0;
      fstop_q <= 1'b0;
      sel_q   <= 1'b1;
    end else begin
      lock_q  <= lock_d;
      rstop_q <= rstop_d;
      fstop_q <= fstop_d;
      sel_q   <= sel_d;
    end
  end

  // reconfiguration port; accesses start and end on port clock rising edges, the commit countdown runs on system cycles
  logic [15:0] cells_q [0:`CKM_CELL_DEPTH-1];
  ckm_pkg::ckm_port_e st_q, st_d;
  ckm_pkg::ckm_addr_t sh_addr_q, sh_addr_d;
  ckm_pkg::ckm_word_t sh_data_q, sh_data_d, rd_q, rd_d;
  logic rdy_q, rdy_d, commit_go;
  logic [7:0] cmt_q, cmt_d;
  always_comb begin
    st_d      = st_q;
    sh_addr_d = sh_addr_q;
    sh_data_d = sh_data_q;
    rd_d      = rd_q;
    rdy_d     = rdy_q;
    cmt_d     = cmt_q;
    commit_go = 1'b0;
    if (cfg_clk_rise) rdy_d = 1'b0;
    unique case (st_q)
      ckm_pkg::CKM_PORT_IDLE: begin
        if (cfg_clk_rise && den_lvl && !hold) begin
          sh_addr_d = addr_q;
          if (dwe_lvl) begin
            sh_data_d = wd_q;
            st_d      = ckm_pkg::CKM_PORT_WRITE;
          end else begin
            st_d = ckm_pkg::CKM_PORT_READ;
          end
        end
      end
      ckm_pkg::CKM_PORT_READ: begin
        if (cfg_clk_rise) begin
          rd_d  = cells_q[sh_addr_q];
          rdy_d = 1'b1;
          st_d  = ckm_pkg::CKM_PORT_IDLE;
        end
      end
      ckm_pkg::CKM_PORT_WRITE: begin
        cmt_d = 8'(`CKM_COMMIT_CYC);
        st_d  = ckm_pkg::CKM_PORT_COMMIT;
      end
      ckm_pkg::CKM_PORT_COMMIT: begin
        // strobes arriving during commit are ignored until ready
        if (cmt_q != 8'h00) begin
          cmt_d = cmt_q - 8'h01;
        end else if (cfg_clk_rise) begin
          commit_go = 1'b1;
          rdy_d     = 1'b1;
          st_d      = ckm_pkg::CKM_PORT_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ckm_pkg::CKM_PORT_IDLE;
      sh_addr_q <= 7'h00;
      sh_data_q <= 16'h0000;
      rd_q      <= 16'h0000;
      rdy_q     <= 1'b0;
      cmt_q     <= 8'h00;
    end else begin
      st_q      <= st_d;
      sh_addr_q <= sh_addr_d;
      sh_data_q <= sh_data_d;
      rd_q      <= rd_d;
      rdy_q     <= rdy_d;
      cmt_q     <= cmt_d;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < `CKM_CELL_DEPTH; gi = gi + 1) begin : g_cell
      logic [15:0] cell_d;
      always_comb begin
        cell_d = (commit_go && sh_addr_q == 7'(gi)) ? sh_data_q : cells_q[gi];
      end
      always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) cells_q[gi] <= `CKM_CELL_RST;
        else        cells_q[gi] <= cell_d;
      end
    end
  endgenerate

  // phase step engine, paced by the phase step clock
  logic ps_busy_q, ps_busy_d, ps_done_q, ps_done_d, ps_dir_q, ps_dir_d;
  logic [7:0]  ps_cnt_q, ps_cnt_d;
  logic [15:0] ps_pos_q, ps_pos_d;
  always_comb begin
    ps_busy_d = ps_busy_q;
    ps_dir_d  = ps_dir_q;
    ps_cnt_d  = ps_cnt_q;
    ps_pos_d  = ps_pos_q;
    ps_done_d = ps_done_q;
    if (sclk_rise) ps_done_d = 1'b0;
    if (hold) begin
      ps_busy_d = 1'b0;
    end else if (!ps_busy_q) begin
      if (sclk_rise && go_lvl) begin
        ps_busy_d = 1'b1;
        ps_dir_d  = dir_lvl;
        ps_cnt_d  = 8'(`CKM_PS_CYC);
      end
    end else if (ps_cnt_q != 8'h00) begin
      ps_cnt_d = ps_cnt_q - 8'h01;
    end else if (sclk_rise) begin
      // position wraps freely, there is no overflow
      ps_pos_d  = ps_dir_q ? ps_pos_q + 16'h0001 : ps_pos_q - 16'h0001;
      ps_done_d = 1'b1;
      ps_busy_d = 1'b0;
    end
  end
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ps_busy_q <= 1'b0;
      ps_dir_q  <= 1'b0;
      ps_cnt_q  <= 8'h00;
      ps_pos_q  <= 16'h0000;
      ps_done_q <= 1'b0;
    end else begin
      ps_busy_q <= ps_busy_d;
      ps_dir_q  <= ps_dir_d;
      ps_cnt_q  <= ps_cnt_d;
      ps_pos_q  <= ps_pos_d;
      ps_done_q <= ps_done_d;
    end
  end

  // divide change completes once the request is held, the unit is locked and the port is idle
  logic ack_q, ack_d;
  always_comb begin
    ack_d = req_lvl && lock_q && (st_q == ckm_pkg::CKM_PORT_IDLE);
  end
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else        ack_q <= ack_d;
  end

  assign O_REF_CLK_SEL       = sel_q;
  assign O_LOCKED            = lock_q;
  assign O_REF_CLK_STOP_FLAG = rstop_q;
  assign O_FB_CLK_STOP_FLAG  = fstop_q;
  assign O_CFG_RDATA         = rd_q;
  assign O_CFG_READY         = rdy_q;
  assign O_PHASE_STEP_DONE   = ps_done_q;
  assign O_DIVIDE_CHANGE_ACK = ack_q;
  assign O_PHASE_POS         = ps_pos_q;
endmodule // ckm_ctrl

/* File: tb/ckm_ctrl_props.sv */
// assertion checker for the clock manager control ports
`timescale 1ns/1ps
module ckm_ctrl_props (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RESET_N,
  input wire logic        I_REF_SELECT,
  input wire logic        I_UNIT_RESET,
  input wire logic        I_POWER_DOWN,
  input wire logic        I_CFG_STROBE,
  input wire logic        I_PHASE_STEP_GO,
  input wire logic        I_DIVIDE_CHANGE_REQ,
  input wire logic        O_REF_CLK_SEL,
  input wire logic        O_LOCKED,
  input wire logic        O_REF_CLK_STOP_FLAG,
  input wire logic [15:0] O_CFG_RDATA,
  input wire logic        O_CFG_READY,
  input wire logic        O_PHASE_STEP_DONE,
  input wire logic        O_DIVIDE_CHANGE_ACK,
  input wire logic [15:0] O_PHASE_POS
);
  // one port clock period is about 31 system cycles; edge sampling adds jitter
  localparam int RDY_MIN = 28;
  localparam int RDY_MAX = 34;
  logic [7:0] rdy_len_q, rdy_len_d, idle_q, idle_d, go_age_q, go_age_d;
  always_comb begin
    rdy_len_d = O_CFG_READY ? rdy_len_q + 8'h01 : 8'h00;
    idle_d    = I_CFG_STROBE ? 8'h00 : ((idle_q == 8'hff) ? idle_q : idle_q + 8'h01);
    go_age_d  = I_PHASE_STEP_GO ? 8'h00 : ((go_age_q == 8'hff) ? go_age_q : go_age_q + 8'h01);
  end
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdy_len_q <= 8'h00;
      idle_q    <= 8'hff;
      go_age_q  <= 8'hff;
    end else begin
      rdy_len_q <= rdy_len_d;
      idle_q    <= idle_d;
      go_age_q  <= go_age_d;
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  sequence s_done_pulse;
    O_PHASE_STEP_DONE [*8] ##[1:6] !O_PHASE_STEP_DONE;
  endsequence
  a_ready_max_len: assert property (O_CFG_READY |-> rdy_len_q < RDY_MAX)
    else $error("ready stood too long");
  a_ready_min_len: assert property ($fell(O_CFG_READY) |-> rdy_len_q >= RDY_MIN)
    else $error("ready pulse too short");
  a_ready_needs_strobe: assert property ($rose(O_CFG_READY) |-> idle_q < 8'h46)
    else $error("ready without an access");
  a_rdata_with_ready: assert property (!$stable(O_CFG_RDATA) |-> $rose(O_CFG_READY))
    else $error("read data moved without ready");
  a_step_done_pulse: assert property ($rose(O_PHASE_STEP_DONE) |-> s_done_pulse)
    else $error("step done not one step clock long");
  a_step_done_cause: assert property ($rose(O_PHASE_STEP_DONE) |-> go_age_q >= 8'h1e && go_age_q <= 8'h5a)
    else $error("step done without a request");
  a_step_pos_move: assert property (!$stable(O_PHASE_POS) |-> $rose(O_PHASE_STEP_DONE)
    && (O_PHASE_POS == $past(O_PHASE_POS) + 16'h0001 || O_PHASE_POS == $past(O_PHASE_POS) - 16'h0001))
    else $error("phase position moved wrongly");
  a_ack_cause: assert property ($rose(O_DIVIDE_CHANGE_ACK) |-> $past(I_DIVIDE_CHANGE_REQ) && $past(O_LOCKED))
    else $error("divide ack without request");
  a_ack_drop: assert property (!I_DIVIDE_CHANGE_REQ [*6] |-> !O_DIVIDE_CHANGE_ACK)
    else $error("divide ack held without request");
  a_stop_unlocks: assert property ($rose(O_REF_CLK_STOP_FLAG) |-> ##[0:3] !O_LOCKED)
    else $error("lock kept after reference stop");
  a_pd_quiet: assert property (I_POWER_DOWN [*8] |-> !O_LOCKED && !O_CFG_READY && !O_PHASE_STEP_DONE)
    else $error("activity in power down");
  a_sel_copy: assert property ((!I_POWER_DOWN && !I_UNIT_RESET && $stable(I_REF_SELECT)) [*6]
    |-> O_REF_CLK_SEL == I_REF_SELECT)
    else $error("select not reflected");
endmodule  // ckm_ctrl_props
bind ckm_ctrl ckm_ctrl_props u_ckm_props (.I_CLK_SYS, .I_RESET_N, .I_REF_SELECT, .I_UNIT_RESET, .I_POWER_DOWN,
  .I_CFG_STROBE, .I_PHASE_STEP_GO, .I_DIVIDE_CHANGE_REQ, .O_REF_CLK_SEL, .O_LOCKED, .O_REF_CLK_STOP_FLAG,
  .O_CFG_RDATA, .O_CFG_READY, .O_PHASE_STEP_DONE, .O_DIVIDE_CHANGE_ACK, .O_PHASE_POS);

/* File: tb/ckm_user_model.sv */
// user logic model driving the reconfiguration and phase step ports
`timescale 1ns/1ps
module ckm_user_model (
  input  wire logic        i_cfg_ready,
  input  wire logic [15:0] i_cfg_rdata,
  input  wire logic        i_step_done,
  output logic             o_cfg_clk,
  output logic [6:0]       o_cfg_addr,
  output logic [15:0]      o_cfg_wdata,
  output logic             o_cfg_write_en,
  output logic             o_cfg_strobe,
  output logic             o_step_clk,
  output logic             o_step_go,
  output logic             o_step_dir
);
  initial begin
    o_cfg_clk      = 1'b0;
    o_step_clk     = 1'b0;
    o_cfg_addr     = 7'h00;
    o_cfg_wdata    = 16'h0000;
    o_cfg_write_en = 1'b0;
    o_cfg_strobe   = 1'b0;
    o_step_go      = 1'b0;
    o_step_dir     = 1'b0;
  end
  always #62.5 o_cfg_clk = ~o_cfg_clk;
  always #20 o_step_clk = ~o_step_clk;
  task automatic cfg_access(input logic we, input logic [6:0] a, input logic [15:0] d,
                            output logic [15:0] q, output logic ok);
    int n = 0;
    @(posedge o_cfg_clk);
    o_cfg_addr     <= a;
    o_cfg_wdata    <= d;
    o_cfg_write_en <= we;
    o_cfg_strobe   <= 1'b1;
    // the unit takes the access at this edge; a strobe left high past ready would start a second one
    @(posedge o_cfg_clk);
    o_cfg_strobe   <= 1'b0;
    o_cfg_write_en <= 1'b0;
    // released buses show the inverse, never a stale copy
    o_cfg_addr     <= ~a;
    o_cfg_wdata    <= ~d;
    do begin
      @(posedge o_cfg_clk);
      n++;
    end while (i_cfg_ready !== 1'b1 && n < 8);
    q  = i_cfg_rdata;
    ok = (i_cfg_ready === 1'b1);
  endtask
  task automatic cfg_no_strobe(input logic [6:0] a, input logic [15:0] d);
    @(posedge o_cfg_clk);
    o_cfg_addr     <= a;
    o_cfg_wdata    <= d;
    o_cfg_write_en <= 1'b1;
    repeat (4) @(posedge o_cfg_clk);
    o_cfg_write_en <= 1'b0;
  endtask
  task automatic step(input logic up, output logic ok);
    int n = 0;
    @(posedge o_step_clk);
    o_step_go  <= 1'b1;
    o_step_dir <= up;
    @(posedge o_step_clk);
    o_step_go  <= 1'b0;
    o_step_dir <= ~up;
    while (i_step_done !== 1'b1 && n < 20) begin
      @(posedge o_step_clk);
      n++;
    end
    ok = (i_step_done === 1'b1);
  endtask
endmodule  // ckm_user_model

/* File: tb/ckm_ctrl_tb_top.sv */
// self-checking bench for the clock manager control ports
`timescale 1ns/1ps
`define CKM_CHECK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); \
  end end
module ckm_ctrl_tb_top;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sel = 1'b1;
  logic        unit_rst = 1'b0;
  logic        pd = 1'b0;
  logic        req = 1'b0;
  logic        pri = 1'b0;
  logic        sec = 1'b0;
  logic        fb = 1'b0;
  logic [2:0]  run = 3'b111;
  logic        cclk, cwe, cstb, sclk, sgo, sdir, sel_o, rdy, done, ok;
  logic [6:0]  caddr;
  logic [15:0] cwd, rd, pos, q;
  logic [15:0] p = 16'h0000;
  logic [3:0]  flags;
  logic [22:0] tbl [3];
  initial forever #2 clk = ~clk;
  always #25 pri = run[0] ? ~pri : pri;
  always #35 sec = run[1] ? ~sec : sec;
  always #25 fb = run[2] ? ~fb : fb;
  ckm_ctrl i_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PRIMARY_REF_CLK(pri), .I_SECONDARY_REF_CLK(sec),
    .I_REF_SELECT(sel), .I_FEEDBACK_CLK_IN(fb), .I_UNIT_RESET(unit_rst), .I_POWER_DOWN(pd), .I_CFG_CLK(cclk),
    .I_CFG_ADDR(caddr), .I_CFG_WDATA(cwd), .I_CFG_WRITE_EN(cwe), .I_CFG_STROBE(cstb), .I_PHASE_STEP_CLK(sclk),
    .I_PHASE_STEP_GO(sgo), .I_PHASE_STEP_DIR(sdir), .I_DIVIDE_CHANGE_REQ(req), .O_REF_CLK_SEL(sel_o),
    .O_LOCKED(flags[0]), .O_REF_CLK_STOP_FLAG(flags[1]), .O_FB_CLK_STOP_FLAG(flags[2]), .O_CFG_RDATA(rd),
    .O_CFG_READY(rdy), .O_PHASE_STEP_DONE(done), .O_DIVIDE_CHANGE_ACK(flags[3]), .O_PHASE_POS(pos));
  ckm_user_model u_user (.i_cfg_ready(rdy), .i_cfg_rdata(rd), .i_step_done(done), .o_cfg_clk(cclk),
    .o_cfg_addr(caddr), .o_cfg_wdata(cwd), .o_cfg_write_en(cwe), .o_cfg_strobe(cstb), .o_step_clk(sclk),
    .o_step_go(sgo), .o_step_dir(sdir));
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_flag(input int idx, input logic v, input int lim);
    int n = 0;
    while (flags[idx] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CKM_CHECK(flags[idx], v)
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    tbl = '{{7'h00, 16'h1234}, {7'h7f, 16'hfedc}, {7'h2a, 16'h5a5a}};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CKM_CHECK({flags, rdy, rd, pos, sel_o}, 38'h1)
    wait_flag(0, 1'b1, 2000);
    `CKM_CHECK(flags[2:1], 2'b00)
    foreach (tbl[i]) begin
      u_user.cfg_access(1'b1, tbl[i][22:16], tbl[i][15:0], q, ok);
      `CKM_CHECK(ok, 1'b1)
    end
    foreach (tbl[i]) begin
      u_user.cfg_access(1'b0, tbl[i][22:16], 16'h0000, q, ok);
      `CKM_CHECK({ok, q}, {1'b1, tbl[i][15:0]})
    end
    u_user.cfg_access(1'b0, 7'h01, 16'hffff, q, ok);
    `CKM_CHECK(q, 16'h0000)
    u_user.cfg_no_strobe(7'h00, 16'hdead);
    u_user.cfg_access(1'b0, 7'h00, 16'h0000, q, ok);
    `CKM_CHECK(q, 16'h1234)
    for (int i = 0; i < 5; i++) begin
      u_user.step(i < 2, ok);
      p = (i < 2) ? p + 16'h0001 : p - 16'h0001;
      `CKM_CHECK({ok, pos}, {1'b1, p})
    end
    @(posedge clk);
    req <= 1'b1;
    wait_flag(3, 1'b1, 8);
    req <= 1'b0;
    wait_flag(3, 1'b0, 8);
    run[0] = 1'b0;
    wait_flag(1, 1'b1, 400);
    `CKM_CHECK(flags[0], 1'b0)
    @(posedge clk);
    unit_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    unit_rst <= 1'b0;
    wait_flag(0, 1'b1, 2000);
    wait_flag(1, 1'b0, 50);
    `CKM_CHECK(sel_o, 1'b0)
    run[2] = 1'b0;
    wait_flag(2, 1'b1, 400);
    run[2] = 1'b1;
    @(posedge clk);
    unit_rst <= 1'b1;
    wait_flag(0, 1'b0, 8);
    u_user.cfg_access(1'b1, 7'h2a, 16'h0f0f, q, ok);
    `CKM_CHECK(ok, 1'b0)
    @(posedge clk);
    unit_rst <= 1'b0;
    wait_flag(0, 1'b1, 2000);
    wait_flag(2, 1'b0, 50);
    u_user.cfg_access(1'b0, 7'h2a, 16'h0000, q, ok);
    `CKM_CHECK(q, 16'h5a5a)
    @(posedge clk);
    pd <= 1'b1;
    wait_flag(0, 1'b0, 8);
    u_user.cfg_access(1'b0, 7'h2a, 16'h0000, q, ok);
    `CKM_CHECK(ok, 1'b0)
    @(posedge clk);
    pd <= 1'b0;
    wait_flag(0, 1'b1, 2000);
    give_verdict();
  end
endmodule  // ckm_ctrl_tb_top
